// file: i2c_slave_register_port_test.sv
// Self-checking bench: master and register port joined across the bus
`timescale 1ns/1ns
`include "i2r_regs.svh"
module i2c_slave_register_port_test
    import i2r_pkg::*;
;
    logic        core_clk;
    logic        sys_rst;
    logic        cmd_valid;
    logic        cmd_ready;
    i2r_cmd_type cmd;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        rsp_acked;
    logic        busy;
    logic        vin_ok;
    logic        en_pin;
    logic [7:0]  fault_in;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  vout_set;
    logic        hs_filter;
    logic        saw_full;
    logic [9:0]  mon_e;
    logic [7:0]  wd[3];
    logic [9:0]  exp_q[$];
    int          error_cnt;
    int          checks_done;
    localparam logic [7:0] AW = {`I2R_DEV_ADDR, 1'b0};
    localparam logic [7:0] AR = {`I2R_DEV_ADDR, 1'b1};

    i2r_if bus ();
    i2r_slave u_i2r_slave (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .vin_ok(vin_ok),
        .en_pin(en_pin), .fault_in(fault_in), .cfg1(cfg1), .cfg2(cfg2), .vout_set(vout_set),
        .hs_filter(hs_filter));
    i2r_master u_i2r_master (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_acked(rsp_acked), .busy(busy));
    i2r_props u_i2r_props (.core_clk(core_clk), .sys_rst(sys_rst), .m_scl_o(bus.m_scl_o),
        .m_scl_oe(bus.m_scl_oe), .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe),
        .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));

    // Clock: 50 ns period
    always #25 core_clk = ~core_clk;

    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare and count; an unknown never passes
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Offer one command; valid stays up so back-to-back offers need no gap
    task automatic send(input i2r_op_type op, input logic a, input logic [7:0] d);
        cmd       = '{op, a, d};
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) begin
            saw_full = 1'b1;
            @(posedge core_clk);
            #2;
        end
        @(posedge core_clk);
        #2;
    endtask

    task automatic wr(input logic [7:0] d, input logic ea);
        exp_q.push_back({1'b1, ea, d});
        send(I2R_OP_WRITE, 1'b0, d);
    endtask

    task automatic rd(input logic a, input logic [7:0] ed);
        exp_q.push_back({2'b00, ed});
        send(I2R_OP_READ, a, 8'h00);
    endtask

    // Stop offering, then wait for every response and an idle engine
    task automatic drain();
        int n;
        cmd_valid = 1'b0;
        n = 0;
        while ((exp_q.size() != 0 || busy !== 1'b0 || n < 30) && n < 20000) begin
            @(posedge core_clk);
            #2;
            n++;
        end
        if (n >= 20000) error_cnt++;
    endtask

    // Each byte response is matched against the oldest expectation
    always @(posedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            mon_e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'bx;
            check(rsp_data, mon_e[7:0]);
            if (mon_e[9] === 1'b1) check({7'h0, rsp_acked}, {7'h0, mon_e[8]});
        end
    end

    // Watchdog well past the expected run length
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h9c28));
        core_clk = 1'b0;
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        vin_ok = 1'b1;
        en_pin = 1'b1;
        fault_in = 8'h00;
        error_cnt = 0;
        checks_done = 0;
        saw_full = 1'b0;
        repeat (4) @(posedge core_clk);
        #2;
        sys_rst = 1'b0;
        check(cfg1, `I2R_CFG1_RST);
        check({7'h0, hs_filter}, 8'h00);
        // Long sequential write fills the FIFO until it refuses
        foreach (wd[i]) wd[i] = 8'($urandom());
        send(I2R_OP_START, 1'b0, 8'h00);
        wr(AW, 1'b1);
        wr(`I2R_REG_CFG1, 1'b1);
        for (int i = 0; i < 18; i++) begin
            wr((i < 3) ? wd[i] : 8'($urandom()), 1'b1);
        end
        send(I2R_OP_STOP, 1'b0, 8'h00);
        drain();
        check({7'h0, saw_full}, 8'h01);
        check(cfg1, wd[0]);
        check(cfg2, wd[1]);
        check(vout_set, wd[2]);
        // Sequential reads, status following the live faults
        for (int k = 0; k < 2; k++) begin
            fault_in = 8'($urandom());
            send(I2R_OP_START, 1'b0, 8'h00);
            wr(AW, 1'b1);
            wr(`I2R_REG_ID, 1'b1);
            send(I2R_OP_START, 1'b0, 8'h00);
            wr(AR, 1'b1);
            rd(1'b1, `I2R_ID_VALUE);
            rd(1'b1, fault_in);
            rd(1'b1, wd[0]);
            rd(1'b1, wd[1]);
            rd(1'b0, wd[2]);
            send(I2R_OP_STOP, 1'b0, 8'h00);
            drain();
        end
        // Supply low clears the registers just as enable low does
        vin_ok = 1'b0;
        repeat (5) @(posedge core_clk);
        #2;
        check(cfg1, `I2R_CFG1_RST);
        check(cfg2, `I2R_CFG2_RST);
        vin_ok = 1'b1;
        // General call and a foreign address stay unanswered
        send(I2R_OP_START, 1'b0, 8'h00);
        wr(`I2R_GCALL, 1'b0);
        send(I2R_OP_START, 1'b0, 8'h00);
        wr({`I2R_DEV_ADDR ^ 7'($urandom_range(1, 127)), 1'b0}, 1'b0);
        wr(8'h02, 1'b0);
        send(I2R_OP_STOP, 1'b0, 8'h00);
        drain();
        // Master code, then a fast-filtered write until the stop
        send(I2R_OP_START, 1'b0, 8'h00);
        wr({`I2R_HS_PREFIX, 3'($urandom())}, 1'b0);
        drain();
        check({7'h0, hs_filter}, 8'h01);
        foreach (wd[i]) wd[i] = 8'($urandom());
        send(I2R_OP_START, 1'b0, 8'h00);
        wr(AW, 1'b1);
        wr(`I2R_REG_CFG1, 1'b1);
        foreach (wd[i]) wr(wd[i], 1'b1);
        send(I2R_OP_STOP, 1'b0, 8'h00);
        drain();
        check(cfg1, wd[0]);
        check(vout_set, wd[2]);
        check({7'h0, hs_filter}, 8'h00);
        // Enable low clears the registers after its input sync
        en_pin = 1'b0;
        repeat (5) @(posedge core_clk);
        #2;
        check(vout_set, `I2R_VOUT_RST);
        check(cfg1, `I2R_CFG1_RST);
        en_pin = 1'b1;
        print_verdict();
    end
endmodule

// file: i2r_if.sv
// Two-wire bus between the bus master and the register port
`timescale 1ns/1ns
interface i2r_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wired-and with pull-ups; only the master ever drives the clock
    assign scl = ~(m_scl_oe & ~m_scl_o);
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

    modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                    input scl, input sda);
    modport slave  (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

// file: i2r_master.sv
// Bus master end: command FIFO and two-wire master engine
`timescale 1ns/1ns
`include "i2r_regs.svh"
module i2r_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      n_q, n_d;
    logic             push, pop;

    assign in_ready  = (n_q != (AW+1)'(DEPTH));
    assign out_valid = (n_q != '0);
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and level update
    always_comb begin
        wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
        n_d  = (AW+1)'(n_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            n_q  <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            n_q  <= n_d;
        end
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule

module i2r_master
    import i2r_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Bus
    i2r_if.master            bus,
    // Command stream
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire i2r_cmd_type cmd,
    // Response per byte
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_acked,
    output logic             busy
);
    localparam logic [7:0] QTR = 8'(`I2R_QTR_CYC);
    i2r_cmd_type cur;
    logic        cur_valid, take, tick;
    logic [1:0]  sda_q, sda_d;
    i2r_mst_type st_q, st_d;
    i2r_cmd_type op_q, op_d;
    logic [7:0]  qc_q, qc_d;
    logic [1:0]  ph_q, ph_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  rx_q, rx_d;
    logic        ackin_q, ackin_d;
    logic        scl_q, scl_d, sdo_q, sdo_d;
    logic        rv_q, rv_d;

    // Commands wait here; the engine pulls one only when idle
    i2r_fifo #(.WIDTH($bits(i2r_cmd_type)), .DEPTH(`I2R_FIFO_DEPTH)) u_fifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .in_valid (cmd_valid),
        .in_ready (cmd_ready),
        .in_data  (cmd),
        .out_valid(cur_valid),
        .out_ready(take),
        .out_data (cur)
    );

    assign take = (st_q == I2R_M_IDLE);
    assign tick = (qc_q == 8'(QTR - 8'h01));
    assign sda_d = {sda_q[0], bus.sda};

    // Quarter-period sequencer; data bits change with the clock fall, start and stop edges while the clock is high
    always_comb begin
        st_d    = st_q;
        op_d    = op_q;
        qc_d    = qc_q;
        ph_d    = ph_q;
        bit_d   = bit_q;
        rx_d    = rx_q;
        ackin_d = ackin_q;
        scl_d   = scl_q;
        sdo_d   = sdo_q;
        rv_d    = 1'b0;
        if (st_q == I2R_M_IDLE) begin
            qc_d = 8'h00;
            if (cur_valid) begin
                st_d  = I2R_M_RUN;
                op_d  = cur;
                ph_d  = 2'h0;
                bit_d = 4'h0;
            end
        end else begin
            qc_d = tick ? 8'h00 : 8'(qc_q + 8'h01);
            if (tick) begin
                ph_d = 2'(ph_q + 2'h1);
                unique case (ph_q)
                    2'h0: begin
                        scl_d = 1'b0;
                        unique case (op_q.op)
                            I2R_OP_START: sdo_d = 1'b1;
                            I2R_OP_STOP:  sdo_d = 1'b0;
                            I2R_OP_WRITE: sdo_d = (bit_q == 4'h8) ? 1'b1 : op_q.data[7];
                            I2R_OP_READ:  sdo_d = (bit_q == 4'h8) ? ~op_q.ack : 1'b1;
                        endcase
                    end
                    2'h1: scl_d = 1'b1;
                    2'h2: begin
                        if (op_q.op == I2R_OP_START) sdo_d = 1'b0;
                        if (op_q.op == I2R_OP_STOP) sdo_d = 1'b1;
                        if (bit_q < 4'h8) rx_d = {rx_q[6:0], sda_q[1]};
                        else ackin_d = ~sda_q[1];
                    end
                    2'h3: begin
                        op_d.data = {op_q.data[6:0], 1'b0};
                        bit_d = 4'(bit_q + 4'h1);
                        if (op_q.op == I2R_OP_START || op_q.op == I2R_OP_STOP
                            || bit_q == 4'h8) begin
                            st_d = I2R_M_IDLE;
                            rv_d = (op_q.op == I2R_OP_WRITE || op_q.op == I2R_OP_READ);
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sda_q   <= 2'h3;
            st_q    <= I2R_M_IDLE;
            op_q    <= '0;
            qc_q    <= 8'h00;
            ph_q    <= 2'h0;
            bit_q   <= 4'h0;
            rx_q    <= 8'h00;
            ackin_q <= 1'b0;
            scl_q   <= 1'b1;
            sdo_q   <= 1'b1;
            rv_q    <= 1'b0;
        end else begin
            sda_q   <= sda_d;
            st_q    <= st_d;
            op_q    <= op_d;
            qc_q    <= qc_d;
            ph_q    <= ph_d;
            bit_q   <= bit_d;
            rx_q    <= rx_d;
            ackin_q <= ackin_d;
            scl_q   <= scl_d;
            sdo_q   <= sdo_d;
            rv_q    <= rv_d;
        end
    end

    // Open-drain drive: enable only while pulling low
    assign bus.m_scl_o  = 1'b0;
    assign bus.m_scl_oe = ~scl_q;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_sda_oe = ~sdo_q;
    assign rsp_valid    = rv_q;
    assign rsp_data     = rx_q;
    assign rsp_acked    = ackin_q;
    assign busy         = (st_q == I2R_M_RUN) | cur_valid;
endmodule

// file: i2r_pkg.sv
// Types shared by both ends of the register port
package i2r_pkg;
    typedef enum logic [1:0] {
        I2R_OP_START,
        I2R_OP_STOP,
        I2R_OP_WRITE,
        I2R_OP_READ
    } i2r_op_type;

    // Command word: operation, acknowledge to give on a read, data to write
    typedef struct packed {
        i2r_op_type op;
        logic       ack;
        logic [7:0] data;
    } i2r_cmd_type;

    typedef enum logic [2:0] {
        I2R_S_IDLE,
        I2R_S_ADDR,
        I2R_S_PTR,
        I2R_S_WDATA,
        I2R_S_RDATA
    } i2r_sst_type;

    typedef enum logic {
        I2R_M_IDLE,
        I2R_M_RUN
    } i2r_mst_type;
endpackage

// file: i2r_props.sv
// Concurrent checks on the two-wire bus between master and register port
`timescale 1ns/1ns
`include "i2r_regs.svh"
module i2r_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Line drivers
    input wire logic m_scl_o,
    input wire logic m_scl_oe,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    // Resolved lines
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q;
    logic       sda_q;
    logic       rise;
    logic       start;
    logic       byte0_q;
    logic       byte0_d;
    logic       sel_w_q;
    logic       sel_w_d;
    logic       sel_r_q;
    logic       sel_r_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] sr_q;
    logic [7:0] sr_d;

    // Byte tracker; a start wipes it so every address phase is judged afresh
    always_comb begin
        rise    = scl & ~scl_q;
        start   = scl & scl_q & sda_q & ~sda;
        bit_d   = bit_q;
        sr_d    = sr_q;
        byte0_d = byte0_q;
        sel_w_d = sel_w_q;
        sel_r_d = sel_r_q;
        if (start) begin
            bit_d   = 4'h0;
            byte0_d = 1'b1;
            sel_w_d = 1'b0;
            sel_r_d = 1'b0;
        end else if (rise && bit_q == 4'h8) begin
            bit_d   = 4'h0;
            byte0_d = 1'b0;
            if (byte0_q) begin
                sel_w_d = sr_q == {`I2R_DEV_ADDR, 1'b0};
                sel_r_d = sr_q == {`I2R_DEV_ADDR, 1'b1};
            end
        end else if (rise) begin
            bit_d = bit_q + 4'h1;
            sr_d  = {sr_q[6:0], sda};
        end
    end

    // Registers of the tracker; lines idle high
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            bit_q   <= 4'h0;
            sr_q    <= 8'h00;
            byte0_q <= 1'b0;
            sel_w_q <= 1'b0;
            sel_r_q <= 1'b0;
        end else begin
            scl_q   <= scl;
            sda_q   <= sda;
            bit_q   <= bit_d;
            sr_q    <= sr_d;
            byte0_q <= byte0_d;
            sel_w_q <= sel_w_d;
            sel_r_q <= sel_r_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_clock_master_only: assert property (!(m_scl_oe && !m_scl_o) |-> scl)
        else $error("clock line low without the master pulling it");
    chk_addr_ack_match: assert property (rise && byte0_q && bit_q == 4'h8
        |-> s_sda_oe == (sr_q[7:1] == `I2R_DEV_ADDR))
        else $error("address acknowledge does not match the address");
    chk_write_byte_ack: assert property (rise && !byte0_q && bit_q == 4'h8 && sel_w_q
        |-> s_sda_oe)
        else $error("written byte not acknowledged");
    chk_read_slot_free: assert property (rise && !byte0_q && bit_q == 4'h8 && sel_r_q
        |-> !s_sda_oe)
        else $error("port holds data line in master acknowledge slot");
    chk_stable_high: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
        else $error("port data changed while clock high");
    chk_no_condition: assert property (scl && $past(scl) && $changed(sda)
        |-> !s_sda_oe && !$past(s_sda_oe))
        else $error("port made a start or stop");
    chk_late_answer: assert property ($fell(scl) |=> $stable(s_sda_oe))
        else $error("port answered before its input sync");
    chk_bit_stands: assert property ($rose(s_sda_oe) |=> s_sda_oe [*8])
        else $error("driven bit released early");
    chk_change_low: assert property ($changed(s_sda_oe) |-> !scl && !$past(scl))
        else $error("port data changed near clock high");
endmodule

// file: i2r_regs.svh
// Register indices, reset values, bus codes and timing counts of the register port
`ifndef I2R_REGS_SVH
`define I2R_REGS_SVH
`define I2R_DEV_ADDR     7'h43
`define I2R_GCALL        8'h00
`define I2R_HS_PREFIX    5'h01
`define I2R_NREG         5
`define I2R_REG_ID       8'h00
`define I2R_REG_STATUS   8'h01
`define I2R_REG_CFG1     8'h02
`define I2R_REG_CFG2     8'h03
`define I2R_REG_VOUT     8'h04
`define I2R_ID_VALUE     8'h5a
`define I2R_CFG1_RST     8'h00
`define I2R_CFG2_RST     8'h00
`define I2R_VOUT_RST     8'h00
`define I2R_CLK_NS       50
`define I2R_SCL_NS       1000
`define I2R_QTR_CYC      ((`I2R_SCL_NS) / (4 * `I2R_CLK_NS))
`define I2R_FIFO_DEPTH   16
`endif

// file: i2r_slave.sv
// Register port end: two-wire slave with pointer and five registers
`timescale 1ns/1ns
`include "i2r_regs.svh"
module i2r_slave
    import i2r_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Bus
    i2r_if.slave            bus,
    // Supply and enable pins
    input  wire logic       vin_ok,
    input  wire logic       en_pin,
    // Live fault conditions
    input  wire logic [7:0] fault_in,
    // Register contents to the regulator
    output logic [7:0]      cfg1,
    output logic [7:0]      cfg2,
    output logic [7:0]      vout_set,
    // Input filter select, high for high-speed filtering
    output logic            hs_filter
);
    logic [2:0]  scl_q, scl_d;
    logic [2:0]  sda_q, sda_d;
    logic [1:0]  vin_q, vin_d;
    logic [1:0]  en_q, en_d;
    logic        scl_rise, scl_fall, start_ev, stop_ev, clear_regs;
    i2r_sst_type st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [7:0]  shr_q, shr_d;
    logic [7:0]  tx_q, tx_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        rw_q, rw_d;
    logic        oe_q, oe_d;
    logic        mack_q, mack_d;
    logic        hs_q, hs_d;
    logic [7:0]  regs_q [`I2R_NREG];
    logic [7:0]  regs_d [`I2R_NREG];
    logic [7:0]  rd_cur, rd_next;

    // Pin synchronisers; only stages 1 and 2 are read by logic
    always_comb begin
        scl_d = {scl_q[1:0], bus.scl};
        sda_d = {sda_q[1:0], bus.sda};
        vin_d = {vin_q[0], vin_ok};
        en_d  = {en_q[0], en_pin};
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            vin_q <= 2'h0;
            en_q  <= 2'h0;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
            vin_q <= vin_d;
            en_q  <= en_d;
        end
    end

    // Bus events; start and stop are data edges while the clock stays high
    assign scl_rise   = scl_q[1] & ~scl_q[2];
    assign scl_fall   = ~scl_q[1] & scl_q[2];
    assign start_ev   = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign stop_ev    = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    assign clear_regs = ~vin_q[1] | ~en_q[1];

    // Register readback; the status register shows the live faults
    function automatic logic [7:0] rd_reg(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx == `I2R_REG_ID) begin
            v = `I2R_ID_VALUE;
        end else if (idx == `I2R_REG_STATUS) begin
            v = fault_in;
        end else if (idx < 8'(`I2R_NREG)) begin
            v = regs_q[idx[2:0]];
        end
        return v;
    endfunction

    // A process rather than assigns, so a change of the live faults is seen at once
    always_comb begin
        rd_cur  = rd_reg(ptr_q);
        rd_next = rd_reg(8'(ptr_q + 8'h01));
    end

    // Protocol engine: bits shift in on rising clock, drive changes on falling clock
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        shr_d  = shr_q;
        tx_d   = tx_q;
        ptr_d  = ptr_q;
        rw_d   = rw_q;
        oe_d   = oe_q;
        mack_d = mack_q;
        hs_d   = hs_q;
        regs_d = regs_q;
        if (stop_ev) begin
            st_d = I2R_S_IDLE;
            oe_d = 1'b0;
            hs_d = 1'b0;
        end else if (start_ev) begin
            st_d  = I2R_S_ADDR;
            // The fall that follows a start carries no bit; it wraps the count to zero
            cnt_d = 4'hf;
            oe_d  = 1'b0;
        end else if (scl_rise && st_q != I2R_S_IDLE) begin
            if (cnt_q < 4'h8) begin
                shr_d = {shr_q[6:0], sda_q[1]};
            end else if (st_q == I2R_S_RDATA) begin
                mack_d = ~sda_q[1];
            end
        end else if (scl_fall && st_q != I2R_S_IDLE) begin
            if (cnt_q == 4'h7) begin
                cnt_d = 4'h8;
                oe_d  = 1'b0;
                unique case (st_q)
                    I2R_S_ADDR: begin
                        if (shr_q[7:1] == `I2R_DEV_ADDR) begin
                            oe_d = 1'b1;
                            rw_d = shr_q[0];
                        end else if (shr_q[7:3] == `I2R_HS_PREFIX) begin
                            hs_d = 1'b1;
                            st_d = I2R_S_IDLE;
                        end else begin
                            st_d = I2R_S_IDLE;
                        end
                    end
                    I2R_S_PTR:   oe_d = 1'b1;
                    I2R_S_WDATA: oe_d = 1'b1;
                    I2R_S_RDATA: oe_d = 1'b0;
                    I2R_S_IDLE:  oe_d = 1'b0;
                endcase
            end else if (cnt_q == 4'h8) begin
                cnt_d = 4'h0;
                oe_d  = 1'b0;
                unique case (st_q)
                    I2R_S_ADDR: begin
                        if (rw_q) begin
                            st_d = I2R_S_RDATA;
                            tx_d = rd_cur;
                            oe_d = ~rd_cur[7];
                        end else begin
                            st_d = I2R_S_PTR;
                        end
                    end
                    I2R_S_PTR: begin
                        ptr_d = shr_q;
                        st_d  = I2R_S_WDATA;
                    end
                    I2R_S_WDATA: begin
                        if (ptr_q >= `I2R_REG_CFG1 && ptr_q < 8'(`I2R_NREG)) begin
                            regs_d[ptr_q[2:0]] = shr_q;
                        end
                        ptr_d = 8'(ptr_q + 8'h01);
                    end
                    I2R_S_RDATA: begin
                        ptr_d = 8'(ptr_q + 8'h01);
                        if (mack_q) begin
                            tx_d = rd_next;
                            oe_d = ~rd_next[7];
                        end else begin
                            st_d = I2R_S_IDLE;
                        end
                    end
                    I2R_S_IDLE: st_d = I2R_S_IDLE;
                endcase
            end else begin
                cnt_d = 4'(cnt_q + 4'h1);
                if (st_q == I2R_S_RDATA) begin
                    tx_d = {tx_q[6:0], 1'b0};
                    oe_d = ~tx_q[6];
                end
            end
        end
        if (clear_regs) begin
            regs_d[2] = `I2R_CFG1_RST;
            regs_d[3] = `I2R_CFG2_RST;
            regs_d[4] = `I2R_VOUT_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q   <= I2R_S_IDLE;
            cnt_q  <= 4'h0;
            shr_q  <= 8'h00;
            tx_q   <= 8'h00;
            ptr_q  <= 8'h00;
            rw_q   <= 1'b0;
            oe_q   <= 1'b0;
            mack_q <= 1'b0;
            hs_q   <= 1'b0;
            for (int i = 0; i < `I2R_NREG; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            shr_q  <= shr_d;
            tx_q   <= tx_d;
            ptr_q  <= ptr_d;
            rw_q   <= rw_d;
            oe_q   <= oe_d;
            mack_q <= mack_d;
            hs_q   <= hs_d;
            regs_q <= regs_d;
        end
    end

    // Data pin pulls low only; there is no clock output at all, so no stretching
    assign bus.s_sda_o  = 1'b0;
    assign bus.s_sda_oe = oe_q;
    assign cfg1         = regs_q[2];
    assign cfg2         = regs_q[3];
    assign vout_set     = regs_q[4];
    assign hs_filter    = hs_q;
endmodule
